// ---- logic/rxfib_pkg.sv ----
/*
 Constants for the receive FIFO index and frame buffer block.
 Assumes a single clock and a plain strobe register port.
*/
package rxfib_pkg;
	// ************************************************************
	// Widths
	// ************************************************************
	localparam int ADDR_W      = 12;
	localparam int DATA_W      = 32;
	localparam int IDX_W       = 6;
	localparam int NUM_BUF     = 4;
	localparam int NUM_FILT    = 5;
	localparam int FILT_STRIDE = 8;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [11:0] OFF_GLOBAL_IRQ_FLAG_ENABLE_REG  = 12'h000;
	localparam logic [11:0] OFF_RDIX_A = 12'h001;
	localparam logic [11:0] OFF_RDIX_B = 12'h002;
	localparam logic [11:0] OFF_SHIX   = 12'h003;
	localparam logic [11:0] OFF_SIDX_A = 12'h004;
	localparam logic [11:0] OFF_SIDX_B = 12'h005;
	localparam logic [11:0] OFF_DEP_A  = 12'h006;
	localparam logic [11:0] OFF_DEP_B  = 12'h007;
	localparam logic [11:0] OFF_FILT   = 12'h010;
	localparam logic [11:0] OFF_BCS    = 12'h020;
	localparam logic [11:0] FRM_BASE   = 12'h800;
	localparam int          FRM_BIT    = 11;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int SHIX_B_LSB = 8;
	localparam int BCS_CMT    = 0;
	localparam int BCS_LCK    = 1;
	localparam int BCS_EDT    = 2;
	localparam int BCS_IE     = 3;
	localparam int BCS_EN_ST  = 4;
	localparam int BCS_LCK_ST = 5;
	localparam int BCS_FULL   = 6;
	localparam int BCS_IDX    = 8;
	localparam int BCS_CH     = 14;
	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [5:0]  IDX_RST  = 6'h00;
	localparam logic [15:0] FILT_RST = 16'h0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
endpackage

// ---- logic/rxfib_hdr_mem.sv ----
/*
 Header area memory: one write port, two registered read ports.
 Assumes the caller arbitrates the single write port.
*/
`timescale 1ns/1ps
module rxfib_hdr_mem #(
	parameter int DW = 32,
	parameter int AW = 6
) (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	// Write port
	input  wire logic          we_in,
	input  wire logic [AW-1:0] wa_in,
	input  wire logic [DW-1:0] wd_in,
	// Read ports
	input  wire logic [AW-1:0] ra0_in,
	output logic      [DW-1:0] rd0_out,
	input  wire logic [AW-1:0] ra1_in,
	output logic      [DW-1:0] rd1_out
);
	logic [DW-1:0] mem [2**AW];

	// ************************************************************
	// Storage
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[wa_in] <= wd_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd0_out <= '0;
			rd1_out <= '0;
		end else begin
			rd0_out <= mem[ra0_in];
			rd1_out <= mem[ra1_in];
		end
	end
endmodule

// ---- logic/rxfib_top.sv ----
/*
 Receive FIFO read index control, buffer triggers and header capture.
 Assumes protocol engine events at least two cycles apart.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module rxfib_top #(
	parameter int IW = rxfib_pkg::IDX_W,
	parameter int NB = rxfib_pkg::NUM_BUF
) (
	// Clock and reset
	input  wire logic                  CORE_CLK_IN,
	input  wire logic                  RST_IN,
	// Register port
	input  wire logic [11:0]           ADDR_IN,
	input  wire logic [31:0]           WDATA_IN,
	input  wire logic                  WR_IN,
	input  wire logic                  RD_IN,
	output logic      [31:0]           RDATA_OUT,
	// Protocol state
	input  wire logic                  PROTOCOL_NORMAL_ACTIVE_STATE_IN,
	input  wire logic                  PROTOCOL_NORMAL_PASSIVE_STATE_IN,
	// Receive events
	input  wire logic                  RX_DONE_IN,
	input  wire logic                  RX_CH_IN,
	input  wire logic                  RX_VALID_IN,
	input  wire logic                  RX_FIFO_IN,
	input  wire logic [$clog2(NB)-1:0] RX_BUF_IN,
	input  wire logic [31:0]           RX_HDR_IN,
	// Transmit header fetch
	input  wire logic                  TX_REQ_IN,
	input  wire logic [IW-1:0]         TX_IDX_IN,
	output logic      [31:0]           TX_HDR_OUT,
	output logic                       TX_HDR_VALID_OUT,
	// Status
	output logic      [1:0]            FIFO_NONEMPTY_OUT
);
	typedef struct packed {
		logic [1:0][IW-1:0]         rd;
		logic [1:0][IW-1:0]         wr;
		logic [1:0][IW-1:0]         sidx;
		logic [1:0][IW-1:0]         dep;
		logic [1:0]                 ne;
		logic [1:0][4:0][15:0]      filt;
		logic [1:0][IW-1:0]         shidx;
		logic [NB-1:0][IW-1:0]      bidx;
		logic [NB-1:0][1:0]         bch;
		logic [NB-1:0]              ben;
		logic [NB-1:0]              block;
		logic [NB-1:0]              bfull;
		logic [NB-1:0]              bie;
		logic                       pend;
		logic [IW-1:0]              pidx;
		logic [31:0]                phdr;
		logic [31:0]                rdata;
		logic                       rmem;
		logic                       txv;
	} rxfib_state_t;

	rxfib_state_t  s_q;
	rxfib_state_t  s_d;
	logic [1:0][IW-1:0] last;
	logic [1:0][IW-1:0] rd_nxt;
	logic [1:0][IW-1:0] wr_nxt;
	logic [1:0]    upd;
	logic          is_mem;
	logic          normal;
	logic          mem_we;
	logic [IW-1:0] mem_wa;
	logic [31:0]   mem_wd;
	logic [31:0]   mem_rd0;

	assign is_mem = ADDR_IN[rxfib_pkg::FRM_BIT];
	assign normal = PROTOCOL_NORMAL_ACTIVE_STATE_IN
		| PROTOCOL_NORMAL_PASSIVE_STATE_IN;

	// ************************************************************
	// Per channel index arithmetic
	// ************************************************************
	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign last[c] = IW'(s_q.sidx[c] + s_q.dep[c]);
		assign rd_nxt[c] = (s_q.rd[c] == last[c]) ? s_q.sidx[c]
			: IW'(s_q.rd[c] + 1'b1);
		assign wr_nxt[c] = (s_q.wr[c] == last[c]) ? s_q.sidx[c]
			: IW'(s_q.wr[c] + 1'b1);
		assign upd[c] = WR_IN && (ADDR_IN == rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG)
			&& WDATA_IN[c];
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [$clog2(NB)-1:0] n;
		n = RX_BUF_IN;
		s_d = s_q;
		s_d.pend = 1'b0;
		s_d.txv = TX_REQ_IN;
		mem_we = s_q.pend;
		mem_wa = s_q.pidx;
		mem_wd = s_q.phdr;
		if (!s_q.pend && WR_IN && is_mem) begin
			mem_we = 1'b1;
			mem_wa = ADDR_IN[IW-1:0];
			mem_wd = WDATA_IN;
		end
		// Shadow capture of every frame
		if (RX_DONE_IN) begin
			mem_we = 1'b1;
			mem_wa = s_q.shidx[RX_CH_IN];
			mem_wd = RX_HDR_IN;
			s_d.phdr = RX_HDR_IN;
		end
		// Valid frame to FIFO or individual buffer
		if (RX_DONE_IN && RX_VALID_IN && RX_FIFO_IN) begin
			s_d.pend = 1'b1;
			s_d.pidx = s_q.wr[RX_CH_IN];
			s_d.wr[RX_CH_IN] = wr_nxt[RX_CH_IN];
		end else if (RX_DONE_IN && RX_VALID_IN && s_q.ben[n]
			&& !s_q.block[n] && !s_q.bfull[n]
			&& s_q.bch[n][RX_CH_IN]) begin
			s_d.pend = 1'b1;
			s_d.pidx = s_q.bidx[n];
			s_d.bfull[n] = 1'b1;
		end
		// Host register writes
		if (WR_IN) begin
			for (int c = 0; c < 2; c++) begin
				if (ADDR_IN == 12'(rxfib_pkg::OFF_SIDX_A + c)) begin
					s_d.sidx[c] = WDATA_IN[IW-1:0];
					s_d.rd[c] = WDATA_IN[IW-1:0];
					s_d.wr[c] = WDATA_IN[IW-1:0];
				end
				if (ADDR_IN == 12'(rxfib_pkg::OFF_DEP_A + c)) begin
					s_d.dep[c] = WDATA_IN[IW-1:0];
				end
				for (int k = 0; k < rxfib_pkg::NUM_FILT; k++) begin
					if (ADDR_IN == 12'(rxfib_pkg::OFF_FILT
						+ c * rxfib_pkg::FILT_STRIDE + k)) begin
						s_d.filt[c][k] = WDATA_IN[15:0];
					end
				end
			end
			if (ADDR_IN == rxfib_pkg::OFF_SHIX && !normal) begin
				s_d.shidx[0] = WDATA_IN[IW-1:0];
				s_d.shidx[1] = WDATA_IN[rxfib_pkg::SHIX_B_LSB +: IW];
			end
			for (int b = 0; b < NB; b++) begin
				if (ADDR_IN == 12'(rxfib_pkg::OFF_BCS + b)) begin
					if (WDATA_IN[rxfib_pkg::BCS_CMT]) begin
						// Capture in the same cycle wins over commit
						s_d.bfull[b] = !s_q.bfull[b] && s_d.bfull[b];
					end
					if (WDATA_IN[rxfib_pkg::BCS_LCK]) begin
						s_d.block[b] = !s_q.block[b];
					end
					if (WDATA_IN[rxfib_pkg::BCS_EDT]) begin
						s_d.ben[b] = !s_q.ben[b];
					end
					s_d.bie[b] = WDATA_IN[rxfib_pkg::BCS_IE];
					if (!s_q.ben[b]) begin
						s_d.bidx[b] = WDATA_IN[rxfib_pkg::BCS_IDX +: IW];
						s_d.bch[b] = WDATA_IN[rxfib_pkg::BCS_CH +: 2];
					end
				end
			end
		end
		// Read index update and not-empty flags
		for (int c = 0; c < 2; c++) begin
			if (upd[c]) begin
				s_d.rd[c] = rd_nxt[c];
			end
			s_d.ne[c] = (s_d.rd[c] != s_d.wr[c]);
		end
		// Host register reads
		s_d.rmem = RD_IN && is_mem;
		s_d.rdata = rxfib_pkg::DATA_RST;
		if (RD_IN) begin
			case (ADDR_IN)
				rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG:  s_d.rdata = 32'(s_q.ne);
				rxfib_pkg::OFF_RDIX_A: s_d.rdata = 32'(s_q.rd[0]);
				rxfib_pkg::OFF_RDIX_B: s_d.rdata = 32'(s_q.rd[1]);
				rxfib_pkg::OFF_SHIX: begin
					s_d.rdata = 32'(s_q.shidx[0]);
					s_d.rdata[rxfib_pkg::SHIX_B_LSB +: IW] = s_q.shidx[1];
				end
				rxfib_pkg::OFF_SIDX_A: s_d.rdata = 32'(s_q.sidx[0]);
				rxfib_pkg::OFF_SIDX_B: s_d.rdata = 32'(s_q.sidx[1]);
				rxfib_pkg::OFF_DEP_A:  s_d.rdata = 32'(s_q.dep[0]);
				rxfib_pkg::OFF_DEP_B:  s_d.rdata = 32'(s_q.dep[1]);
				default: begin
					for (int c = 0; c < 2; c++) begin
						for (int k = 0; k < rxfib_pkg::NUM_FILT; k++) begin
							if (ADDR_IN == 12'(rxfib_pkg::OFF_FILT
								+ c * rxfib_pkg::FILT_STRIDE + k)) begin
								s_d.rdata = 32'(s_q.filt[c][k]);
							end
						end
					end
					for (int b = 0; b < NB; b++) begin
						if (ADDR_IN == 12'(rxfib_pkg::OFF_BCS + b)) begin
							s_d.rdata[rxfib_pkg::BCS_IE] = s_q.bie[b];
							s_d.rdata[rxfib_pkg::BCS_EN_ST] = s_q.ben[b];
							s_d.rdata[rxfib_pkg::BCS_LCK_ST] = s_q.block[b];
							s_d.rdata[rxfib_pkg::BCS_FULL] = s_q.bfull[b];
							s_d.rdata[rxfib_pkg::BCS_IDX +: IW] = s_q.bidx[b];
							s_d.rdata[rxfib_pkg::BCS_CH +: 2] = s_q.bch[b];
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Header memory
	// ************************************************************
	rxfib_hdr_mem #(
		.DW (32),
		.AW (IW)
	) u_mem (
		.clk_in  (CORE_CLK_IN),
		.rst_in  (RST_IN),
		.we_in   (mem_we),
		.wa_in   (mem_wa),
		.wd_in   (mem_wd),
		.ra0_in  (ADDR_IN[IW-1:0]),
		.rd0_out (mem_rd0),
		.ra1_in  (TX_IDX_IN),
		.rd1_out (TX_HDR_OUT)
	);

	assign RDATA_OUT = s_q.rmem ? mem_rd0 : s_q.rdata;
	assign TX_HDR_VALID_OUT = s_q.txv;
	assign FIFO_NONEMPTY_OUT = s_q.ne;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	wrap_to_start_a: assert property (upd[0]
		&& s_q.rd[0] == last[0]
		&& ADDR_IN == rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG
		|=> s_q.rd[0] == $past(s_q.sidx[0]))
		else $error("read index did not wrap to start");
	incr_by_one_a: assert property (upd[1] && s_q.rd[1] != last[1]
		|=> s_q.rd[1] == IW'($past(s_q.rd[1]) + 1'b1))
		else $error("read index did not increment");
	zero_holds_a: assert property (!upd[0] && !(WR_IN
		&& ADDR_IN == rxfib_pkg::OFF_SIDX_A) |=> $stable(s_q.rd[0]))
		else $error("read index moved without update");
	empty_update_a: assert property (upd[0] && !s_q.ne[0]
		&& s_q.dep[0] != '0 && !RX_DONE_IN
		|=> FIFO_NONEMPTY_OUT[0])
		else $error("empty fifo update left it empty");
	shadow_write_a: assert property (RX_DONE_IN
		|-> mem_we && mem_wa == s_q.shidx[RX_CH_IN])
		else $error("shadow header not captured");
	shadow_owned_a: assert property (normal |=> $stable(s_q.shidx))
		else $error("shadow index changed in normal state");
	first_valid_a: assert property (RX_DONE_IN && !RX_FIFO_IN
		&& s_q.bfull[RX_BUF_IN] |=> !s_q.pend)
		else $error("full buffer overwritten");
	tx_fetch_a: assert property (TX_REQ_IN |=> TX_HDR_VALID_OUT
		##1 !TX_HDR_VALID_OUT || $past(TX_REQ_IN))
		else $error("transmit header not presented");
	index_read_a: assert property (RD_IN
		&& ADDR_IN == rxfib_pkg::OFF_RDIX_B
		|=> RDATA_OUT == 32'($past(s_q.rd[1])))
		else $error("read index readback wrong");
	lock_toggle_a: assert property (WR_IN
		&& ADDR_IN == rxfib_pkg::OFF_BCS && WDATA_IN[rxfib_pkg::BCS_LCK]
		|=> s_q.block[0] != $past(s_q.block[0]))
		else $error("lock trigger ignored");

	wrap_seen_c: cover property (upd[0] && s_q.rd[0] == last[0]);
	fifo_push_c: cover property (RX_DONE_IN && RX_VALID_IN && RX_FIFO_IN);
	buf_capture_c: cover property (s_q.pend && !$past(RX_FIFO_IN));
endmodule

// ---- dv/rxfib_pe_model.sv ----
/*
 Protocol engine stand-in: issues receive events and header fetches.
 Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps
module rxfib_pe_model (
	// Clock
	input  wire logic        clk_in,
	// Receive events
	output logic             rx_done_out,
	output logic             rx_ch_out,
	output logic             rx_valid_out,
	output logic             rx_fifo_out,
	output logic      [1:0]  rx_buf_out,
	output logic      [31:0] rx_hdr_out,
	// Transmit fetch
	output logic             tx_req_out,
	output logic      [5:0]  tx_idx_out
);
	initial begin
		rx_done_out  = 1'b0;
		rx_ch_out    = 1'b0;
		rx_valid_out = 1'b0;
		rx_fifo_out  = 1'b0;
		rx_buf_out   = 2'h0;
		rx_hdr_out   = 32'h0000_0000;
		tx_req_out   = 1'b0;
		tx_idx_out   = 6'h00;
	end
	// ************************************************************
	// Frame done pulse, events kept at least three cycles apart
	// ************************************************************
	task automatic rx(input logic ch, input logic vld, input logic fifo,
		input logic [1:0] b, input logic [31:0] hdr);
		@(posedge clk_in);
		rx_done_out  <= 1'b1;
		rx_ch_out    <= ch;
		rx_valid_out <= vld;
		rx_fifo_out  <= fifo;
		rx_buf_out   <= b;
		rx_hdr_out   <= hdr;
		@(posedge clk_in);
		rx_done_out  <= 1'b0;
		rx_hdr_out   <= ~hdr;
		rx_ch_out    <= ~ch;
		@(posedge clk_in);
	endtask
	// ************************************************************
	// Header fetch for transmission
	// ************************************************************
	task automatic tx(input logic [5:0] idx);
		@(posedge clk_in);
		tx_req_out <= 1'b1;
		tx_idx_out <= idx;
		@(posedge clk_in);
		tx_req_out <= 1'b0;
		tx_idx_out <= ~idx;
	endtask
endmodule

// ---- dv/rxfib_top_tb_top.sv ----
/*
 Self-checking bench for the receive FIFO index and buffer block.
 Assumes the engine stand-in model in the same folder.
*/
`timescale 1ns/1ps
module rxfib_top_tb_top;
	logic        clk;
	logic        rst;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        nact;
	logic        npas;
	logic        rx_done, rx_ch, rx_vld, rx_fifo;
	logic [1:0]  rx_buf;
	logic [31:0] rx_hdr;
	logic        tx_req;
	logic [5:0]  tx_idx;
	logic [31:0] tx_hdr;
	logic        tx_vld;
	logic [1:0]  nonempty;
	int          n_fail;
	int          n_compared;
	int          cyc;
	logic [31:0] d;
	// ************************************************************
	// Clock, design and engine model
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	rxfib_top dut_u (
		.CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.PROTOCOL_NORMAL_ACTIVE_STATE_IN(nact),
		.PROTOCOL_NORMAL_PASSIVE_STATE_IN(npas),
		.RX_DONE_IN(rx_done), .RX_CH_IN(rx_ch), .RX_VALID_IN(rx_vld),
		.RX_FIFO_IN(rx_fifo), .RX_BUF_IN(rx_buf), .RX_HDR_IN(rx_hdr),
		.TX_REQ_IN(tx_req), .TX_IDX_IN(tx_idx), .TX_HDR_OUT(tx_hdr),
		.TX_HDR_VALID_OUT(tx_vld), .FIFO_NONEMPTY_OUT(nonempty));
	rxfib_pe_model pe_u (
		.clk_in(clk), .rx_done_out(rx_done), .rx_ch_out(rx_ch),
		.rx_valid_out(rx_vld), .rx_fifo_out(rx_fifo), .rx_buf_out(rx_buf),
		.rx_hdr_out(rx_hdr), .tx_req_out(tx_req), .tx_idx_out(tx_idx));
	// ************************************************************
	// Register port tasks and checks
	// ************************************************************
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] v;
		rd_reg(a, v);
		chk(v & m, exp);
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test;
		end
	end
	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		rst = 1'b1; addr = 12'h000; wdata = 32'h0000_0000;
		wr = 1'b0; rd = 1'b0; nact = 1'b0; npas = 1'b0;
		n_fail = 0; n_compared = 0; cyc = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0000);
		wr_reg(rxfib_pkg::OFF_DEP_A, 32'h0000_0002);
		wr_reg(rxfib_pkg::OFF_SIDX_A, 32'h0000_0004);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0004);
		wr_reg(rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG, 32'h0000_0000);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0004);
		wr_reg(rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG, 32'h0000_0001);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0005);
		chk({31'h0, nonempty[0]}, 32'h0000_0001);
		wr_reg(rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG, 32'h0000_0001);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0006);
		wr_reg(rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG, 32'h0000_0001);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0004);
		wr_reg(rxfib_pkg::OFF_DEP_B, 32'h0000_0001);
		wr_reg(rxfib_pkg::OFF_SIDX_B, 32'h0000_000A);
		wr_reg(rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG, 32'h0000_0002);
		rd_chk(rxfib_pkg::OFF_RDIX_B, 32'h0000_003F, 32'h0000_000B);
		chk({31'h0, nonempty[1]}, 32'h0000_0001);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0004);
		wr_reg(rxfib_pkg::OFF_GLOBAL_IRQ_FLAG_ENABLE_REG, 32'h0000_0003);
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0005);
		rd_chk(rxfib_pkg::OFF_RDIX_B, 32'h0000_003F, 32'h0000_000A);
		// Frame capture into FIFO A and the shadow buffer
		wr_reg(rxfib_pkg::OFF_SIDX_A, 32'h0000_0004);
		wr_reg(rxfib_pkg::OFF_SHIX, 32'h0000_1514);
		chk({31'h0, nonempty[0]}, 32'h0000_0000);
		pe_u.rx(1'b0, 1'b1, 1'b1, 2'h0, 32'hA5A5_0001);
		chk({31'h0, nonempty[0]}, 32'h0000_0001);
		rd_chk(12'h804, 32'hFFFF_FFFF, 32'hA5A5_0001);
		pe_u.rx(1'b0, 1'b0, 1'b0, 2'h0, 32'h5A5A_0002);
		rd_chk(12'h814, 32'hFFFF_FFFF, 32'h5A5A_0002);
		// Buffer on both channels: first valid frame wins
		wr_reg(12'h020, 32'h0000_DE00);
		wr_reg(12'h020, 32'h0000_DE04);
		rd_chk(12'h020, 32'h0000_0070, 32'h0000_0010);
		pe_u.rx(1'b1, 1'b1, 1'b0, 2'h0, 32'hBEEF_0003);
		pe_u.rx(1'b0, 1'b1, 1'b0, 2'h0, 32'hBEEF_0004);
		rd_chk(12'h81E, 32'hFFFF_FFFF, 32'hBEEF_0003);
		rd_chk(12'h020, 32'h0000_0070, 32'h0000_0050);
		wr_reg(12'h020, 32'h0000_DE01);
		rd_chk(12'h020, 32'h0000_0070, 32'h0000_0010);
		wr_reg(12'h020, 32'h0000_DE02);
		rd_chk(12'h020, 32'h0000_0070, 32'h0000_0030);
		// Transmit header fetch
		wr_reg(12'h828, 32'h1234_5678);
		pe_u.tx(6'h28);
		#1 chk({31'h0, tx_vld}, 32'h0000_0001);
		chk(tx_hdr, 32'h1234_5678);
		// Shadow indices owned by the device in normal state
		@(posedge clk) nact <= 1'b1;
		wr_reg(rxfib_pkg::OFF_SHIX, 32'h0000_3F3F);
		rd_chk(rxfib_pkg::OFF_SHIX, 32'h0000_3F3F, 32'h0000_1514);
		@(posedge clk) nact <= 1'b0;
		npas <= 1'b1;
		wr_reg(rxfib_pkg::OFF_SHIX, 32'h0000_3F3F);
		rd_chk(rxfib_pkg::OFF_SHIX, 32'h0000_3F3F, 32'h0000_1514);
		@(posedge clk) npas <= 1'b0;
		rd_chk(rxfib_pkg::OFF_RDIX_A, 32'h0000_003F, 32'h0000_0004);
		wr_reg(12'h100, 32'hFFFF_FFFF);
		rd_chk(12'h100, 32'hFFFF_FFFF, 32'h0000_0000);
		end_of_test;
	end
endmodule
